/* File: hdl/gpx_ports.sv */
// Ports C, D, E with the parallel slave data port, on AHB-Lite.
//
// Contract
// - Each of the eight port D pins has its own direction bit.
// - Slave mode select turns port D into an external 8-bit data port.
// - In slave mode port E pins 2..0 are the read, store, select inputs.
// - Port E bit 3 is input only and reads only when the fuse is zero.
// - Port E pins set as analog read back as zero.
// - Port E direction bits drive the buffers even when pins are analog.
// - After power-on port E pins 2..0 are analog and read as zero.
// - Read strobe low with select low drives the port D latch out.
// - Store strobe low with select low latches the port D pins.
// - Select high deselects; strobes act only while it is low.
// - Port E direction bit 3 does nothing and reads as one.
// - Reset loads all ones into port D direction.
// - Port C bits 3..7 can carry the serial peripheral lines.
// - Port C bits 0..2 can carry timer and capture/compare lines.
// - Direction one makes a pin an input; zero drives the latch.
`include "gpx_cfg.svh"
`timescale 1ns/1ns
module gpx_ports (
  // Bus.
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Port C.
  input wire logic [7:0] port_c_in,
  output logic [7:0] port_c_out,
  output logic [7:0] port_c_oe,
  // Port C peripheral lines.
  input wire logic [7:0] periph_out,
  input wire logic [7:0] periph_oe,
  // Port D.
  input wire logic [7:0] port_d_in,
  output logic [7:0] port_d_out,
  output logic [7:0] port_d_oe,
  // Port E.
  input wire logic [3:0] port_e_in,
  output logic [2:0] port_e_out,
  output logic [2:0] port_e_oe,
  // Fuse and analog view.
  input wire logic reset_pin_enable_fuse,
  output logic [2:0] port_e_analog_sel
);
  gpx_pin_if c_if ();
  gpx_pin_if d_if ();

  gpx_pkg::gpx_byte_t port_c_latch_reg;
  gpx_pkg::gpx_byte_t port_d_latch_reg;
  gpx_pkg::gpx_byte_t port_d_in_reg;
  logic [2:0] port_e_latch_reg;
  gpx_pkg::gpx_byte_t port_c_dir_reg;
  gpx_pkg::gpx_byte_t port_d_dir_reg;
  gpx_pkg::gpx_byte_t port_e_ctrl_reg;
  gpx_pkg::gpx_byte_t analog_cfg_reg;
  gpx_pkg::gpx_byte_t periph_sel_reg;
  logic [7:0] periph_en_reg;
  gpx_pkg::gpx_slave_state_t slave_state_reg;
  gpx_pkg::gpx_slave_state_t slave_state_next;

  logic wr_pend_reg;
  logic [7:0] wr_idx_reg;

  // Bus decode.
  wire take = hsel & hready & htrans[1];
  wire [7:0] a_idx = haddr[9:2];
  wire wr_go = wr_pend_reg;
  wire [7:0] wb = hwdata[7:0];
  wire slave_mode = port_e_ctrl_reg[`GPX_SLAVE_MODE_BIT];
  wire [2:0] e_digital = ~analog_cfg_reg[2:0];

  // Parallel slave strobes (read, store, select on port E 0..2).
  wire read_n = port_e_in[0];
  wire store_n = port_e_in[1];
  wire select_n = port_e_in[2];
  wire ext_read = slave_mode & ~select_n & ~read_n;
  wire ext_store = slave_mode & ~select_n & ~store_n;

  always_comb begin
    slave_state_next = gpx_pkg::GPX_IDLE;
    if (ext_store) begin
      slave_state_next = gpx_pkg::GPX_STORE;
    end else if (ext_read) begin
      slave_state_next = gpx_pkg::GPX_READ;
    end
  end

  // Port E read: analog pins read zero, bit 3 only with fuse at zero.
  wire pe3 = port_e_in[3] & ~reset_pin_enable_fuse;
  wire [2:0] pe_lo = port_e_in[2:0] & e_digital;
  wire [7:0] pe_read = {4'h0, pe3, pe_lo};
  wire [7:0] pd_read = slave_mode ? port_d_in_reg : port_d_in;
  wire [7:0] e_ctrl_read = port_e_ctrl_reg | 8'h08;

  // Read address decode, one named hit per register.
  wire hit_c_data = (a_idx == `GPX_PORT_C_DATA_IDX);
  wire hit_d_data = (a_idx == `GPX_PORT_D_DATA_IDX);
  wire hit_e_data = (a_idx == `GPX_PORT_E_DATA_IDX);
  wire hit_c_dir = (a_idx == `GPX_PORT_C_DIR_IDX);
  wire hit_d_dir = (a_idx == `GPX_PORT_D_DIR_IDX);
  wire hit_e_ctrl = (a_idx == `GPX_PORT_E_CTRL_IDX);
  wire hit_analog = (a_idx == `GPX_ANALOG_CFG_IDX);
  wire hit_psel = (a_idx == `GPX_PERIPH_SEL_IDX);
  wire hit_pen = (a_idx == `GPX_PERIPH_EN_IDX);

  wire [7:0] rd_mux =
    hit_c_data ? port_c_in :
    hit_d_data ? pd_read :
    hit_e_data ? pe_read :
    hit_c_dir ? port_c_dir_reg :
    hit_d_dir ? port_d_dir_reg :
    hit_e_ctrl ? e_ctrl_read :
    hit_analog ? analog_cfg_reg :
    hit_psel ? periph_sel_reg :
    hit_pen ? periph_en_reg : 8'h00;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 8'h00;
      hrdata <= 32'h0;
    end else begin
      wr_pend_reg <= take & hwrite;
      wr_idx_reg <= a_idx;
      if (take & ~hwrite) begin
        hrdata <= {24'h0, rd_mux};
      end
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Write strobes: writes land at the end of the data phase.
  wire wr_c_data = wr_go & (wr_idx_reg == `GPX_PORT_C_DATA_IDX);
  wire wr_d_data = wr_go & (wr_idx_reg == `GPX_PORT_D_DATA_IDX);
  wire wr_e_data = wr_go & (wr_idx_reg == `GPX_PORT_E_DATA_IDX);
  wire wr_c_dir = wr_go & (wr_idx_reg == `GPX_PORT_C_DIR_IDX);
  wire wr_d_dir = wr_go & (wr_idx_reg == `GPX_PORT_D_DIR_IDX);
  wire wr_e_ctrl = wr_go & (wr_idx_reg == `GPX_PORT_E_CTRL_IDX);
  wire wr_analog = wr_go & (wr_idx_reg == `GPX_ANALOG_CFG_IDX);
  wire wr_psel = wr_go & (wr_idx_reg == `GPX_PERIPH_SEL_IDX);
  wire wr_pen = wr_go & (wr_idx_reg == `GPX_PERIPH_EN_IDX);

  // Port C output latch.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_c_latch_reg <= 8'h00;
    end else if (wr_c_data) begin
      port_c_latch_reg <= wb;
    end
  end

  // Port E output latch, pins 2..0 only.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_e_latch_reg <= 3'h0;
    end else if (wr_e_data) begin
      port_e_latch_reg <= wb[2:0];
    end
  end

  // Port C direction.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_c_dir_reg <= `GPX_DIR_RESET;
    end else if (wr_c_dir) begin
      port_c_dir_reg <= wb;
    end
  end

  // Port D direction, all inputs after any reset.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_d_dir_reg <= `GPX_DIR_RESET;
    end else if (wr_d_dir) begin
      port_d_dir_reg <= wb;
    end
  end

  // Port E control: flags read zero and direction bit 3 is fixed at one.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_e_ctrl_reg <= `GPX_E_CTRL_RESET;
    end else if (wr_e_ctrl) begin
      port_e_ctrl_reg <= {3'h0, wb[4], 1'b1, wb[2:0]};
    end
  end

  // Analog selection for port E pins 2..0.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      analog_cfg_reg <= `GPX_ANALOG_RESET;
    end else if (wr_analog) begin
      analog_cfg_reg <= wb;
    end
  end

  // Spare peripheral select, kept readable for software.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      periph_sel_reg <= 8'h00;
    end else if (wr_psel) begin
      periph_sel_reg <= wb;
    end
  end

  // Peripheral enable, one bit per port C pin.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      periph_en_reg <= 8'h00;
    end else if (wr_pen) begin
      periph_en_reg <= wb;
    end
  end

  // Port D latch from software write; input register from external store in slave mode.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_d_latch_reg <= 8'h00;
      port_d_in_reg <= 8'h00;
      slave_state_reg <= gpx_pkg::GPX_IDLE;
    end else begin
      slave_state_reg <= slave_state_next;
      if (slave_state_next == gpx_pkg::GPX_STORE) begin
        port_d_in_reg <= port_d_in;
      end
      if (wr_d_data) begin
        port_d_latch_reg <= wb;
      end
    end
  end

  // Port C: peripheral lines take over selected pins.
  assign c_if.latch = port_c_latch_reg;
  assign c_if.dir = port_c_dir_reg;
  assign c_if.per_sel = periph_en_reg;
  assign c_if.per_out = periph_out;
  assign c_if.per_oe = periph_oe;
  gpx_pin_mux c_mux (.p(c_if));
  assign port_c_out = c_if.pin_o;
  assign port_c_oe = c_if.pin_oe;

  // Port D: the slave port overrides direction in slave mode.
  wire [7:0] d_sel = {8{slave_mode}};
  assign d_if.latch = port_d_latch_reg;
  assign d_if.dir = port_d_dir_reg;
  assign d_if.per_sel = d_sel;
  assign d_if.per_out = port_d_latch_reg;
  assign d_if.per_oe = {8{ext_read}};
  gpx_pin_mux d_mux (.p(d_if));
  assign port_d_out = d_if.pin_o;
  assign port_d_oe = d_if.pin_oe;

  // Port E: direction bits govern drivers even for analog pins.
  assign port_e_out = port_e_latch_reg;
  assign port_e_oe = ~port_e_ctrl_reg[2:0];
  assign port_e_analog_sel = analog_cfg_reg[2:0];

  c_dir_drive_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    port_c_oe == ((periph_en_reg & periph_oe) | (~periph_en_reg & ~port_c_dir_reg)))
    else $error("port c driver wrong");

  dir3_reads_one_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    e_ctrl_read[3] == 1'b1) else $error("dir bit 3 not one");

  slave_drive_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ext_read |-> (port_d_oe == 8'hff && port_d_out == port_d_latch_reg))
    else $error("slave read not driving latch");

  store_latch_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ext_store |=> (port_d_in_reg == $past(port_d_in)))
    else $error("store did not latch pins");

  deselect_quiet_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (slave_mode && select_n) |-> (port_d_oe == 8'h00))
    else $error("driving while deselected");

  gpio_dir_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !slave_mode |-> (port_d_oe == ~port_d_dir_reg))
    else $error("port d direction wrong");

  analog_zero_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (take && !hwrite && a_idx == `GPX_PORT_E_DATA_IDX)
    |=> ((hrdata[2:0] & $past(analog_cfg_reg[2:0])) == 3'h0))
    else $error("analog pin read nonzero");

  fuse_bit3_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    reset_pin_enable_fuse |-> (pe_read[3] == 1'b0))
    else $error("bit 3 visible with fuse set");

  e_dir_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    port_e_oe == ~port_e_ctrl_reg[2:0])
    else $error("port e driver mismatch");

  periph_take_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (periph_en_reg[3] |-> port_c_oe[3] == periph_oe[3]))
    else $error("peripheral not in control");

  slave_quiet_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (slave_mode && !ext_read) |-> (port_d_oe == 8'h00))
    else $error("port d driven outside a slave read");

  e_ctrl_fixed_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (port_e_ctrl_reg[7:5] == 3'h0) && port_e_ctrl_reg[3])
    else $error("port e control fixed bits wrong");

  latch_write_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_c_data |=> (port_c_latch_reg == $past(wb)))
    else $error("port c latch write lost");

  gpio_idle_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !slave_mode |-> (slave_state_next == gpx_pkg::GPX_IDLE))
    else $error("slave strobe acted outside slave mode");

  read_cov: cover property (@(posedge hclk)
    slave_state_reg == gpx_pkg::GPX_READ);
  store_cov: cover property (@(posedge hclk)
    slave_state_reg == gpx_pkg::GPX_STORE);
  mode_cov: cover property (@(posedge hclk) $rose(slave_mode));
  periph_cov: cover property (@(posedge hclk) periph_en_reg != 8'h00);
endmodule

/* File: hdl/gpx_cfg.svh */
// Register offsets, field positions, reset values for the port block.
`ifndef GPX_CFG_SVH
`define GPX_CFG_SVH
`define GPX_PORT_C_DATA_IDX 8'h07
`define GPX_PORT_D_DATA_IDX 8'h08
`define GPX_PORT_E_DATA_IDX 8'h09
`define GPX_PORT_C_DIR_IDX 8'h87
`define GPX_PORT_D_DIR_IDX 8'h88
`define GPX_PORT_E_CTRL_IDX 8'h89
`define GPX_ANALOG_CFG_IDX 8'h9f
`define GPX_PERIPH_SEL_IDX 8'hc0
`define GPX_PERIPH_EN_IDX 8'hc1
`define GPX_DIR_RESET 8'hff
`define GPX_E_CTRL_RESET 8'h0f
// Port E pins 2..0 come out of reset as analog inputs (bit one is analog).
`define GPX_ANALOG_RESET 8'h07
`define GPX_SLAVE_MODE_BIT 4
`define GPX_E_DIR3_BIT 3
`endif

/* File: hdl/gpx_pkg.sv */
// Types shared by the port block.
package gpx_pkg;
  typedef logic [7:0] gpx_byte_t;
  typedef enum logic [1:0] {
    GPX_IDLE = 2'b00,
    GPX_READ = 2'b01,
    GPX_STORE = 2'b10
  } gpx_slave_state_t;
endpackage

/* File: hdl/gpx_pin_if.sv */
// Pin bundle for one 8-bit port slice.
`timescale 1ns/1ns
interface gpx_pin_if;
  logic [7:0] latch;
  logic [7:0] dir;
  logic [7:0] per_sel;
  logic [7:0] per_out;
  logic [7:0] per_oe;
  logic [7:0] pin_o;
  logic [7:0] pin_oe;
  modport ctrl (output latch, dir, per_sel, per_out, per_oe,
                input pin_o, pin_oe);
  modport slice (input latch, dir, per_sel, per_out, per_oe,
                 output pin_o, pin_oe);
endinterface

/* File: hdl/gpx_pin_mux.sv */
// Output mux for one port: peripheral override or general latch.
`timescale 1ns/1ns
module gpx_pin_mux (
  gpx_pin_if.slice p
);
  // Direction one means high impedance, zero drives the latch.
  assign p.pin_o = (p.per_sel & p.per_out) | (~p.per_sel & p.latch);
  assign p.pin_oe = (p.per_sel & p.per_oe) | (~p.per_sel & ~p.dir);
endmodule

/* File: dv/gpx_mpu_model.sv */
// External 8-bit bus master that drives the slave strobes and port D.
`timescale 1ns/1ns
module gpx_mpu_model (
  // Clock.
  input wire logic hclk,
  // Port D wire.
  input wire logic [7:0] port_d_out,
  input wire logic [7:0] port_d_oe,
  output logic [7:0] port_d_in,
  // Strobes: bit 0 read, bit 1 store, bit 2 select, all active low.
  output logic [2:0] e_n
);
  logic [7:0] drv;
  logic [7:0] pat;
  logic drv_en;
  initial begin
    e_n = 3'h7;
    drv = 8'h00;
    pat = 8'h5a;
    drv_en = 1'b0;
  end
  // A released bus shows a changing pattern, never the last byte.
  always @(posedge hclk) pat <= ~pat;
  assign port_d_in = (port_d_oe & port_d_out) |
                     (~port_d_oe & (drv_en ? drv : pat));
  task ext_read(input logic cs, output logic [7:0] d);
    @(posedge hclk);
    e_n <= {~cs, 2'b10};
    repeat (2) @(posedge hclk);
    d = port_d_in;
    e_n <= 3'h7;
  endtask
  task ext_store(input logic cs, input logic [7:0] d);
    @(posedge hclk);
    drv_en <= 1'b1;
    drv <= d;
    e_n <= {~cs, 2'b01};
    repeat (3) @(posedge hclk);
    e_n <= 3'h7;
    @(posedge hclk);
    drv_en <= 1'b0;
  endtask
endmodule

/* File: dv/tb.sv */
// Self-checking bench for the port block.
`timescale 1ns/1ns
module tb;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, fuse, e3;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  logic [7:0] pc_in, pc_out, pc_oe, p_out, p_oe, pd_in, pd_out, pd_oe;
  logic [7:0] v, w, en, got, xoe;
  logic [2:0] pe_out, pe_oe, an_sel, e_n;
  logic [7:0] q[$];
  int n_fail, samples_checked, seed;
  assign hready = hreadyout;
  gpx_ports gpx_ports_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .port_c_in(pc_in),
    .port_c_out(pc_out), .port_c_oe(pc_oe), .periph_out(p_out),
    .periph_oe(p_oe), .port_d_in(pd_in), .port_d_out(pd_out),
    .port_d_oe(pd_oe), .port_e_in({e3, e_n}), .port_e_out(pe_out),
    .port_e_oe(pe_oe), .reset_pin_enable_fuse(fuse),
    .port_e_analog_sel(an_sel));
  gpx_mpu_model gpx_mpu_model_inst (.hclk(hclk), .port_d_out(pd_out),
    .port_d_oe(pd_oe), .port_d_in(pd_in), .e_n(e_n));
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  task end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task wt;
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (hready !== 1'b1 && i < 50);
    if (i >= 50) begin
      n_fail++;
      end_of_test();
    end
  endtask
  task bus(input logic wr_en, input logic [7:0] a, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {22'h0, a, 2'h0};
    hwrite <= wr_en;
    wt();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wt();
    r = hrdata;
    #1;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(r[7:0], e);
  endtask
  initial begin
    seed = 32'h2e6e;
    {hsel, haddr, htrans, hwrite, hwdata, hresetn} = '0;
    {fuse, e3, pc_in, p_out, p_oe, n_fail, samples_checked} = '0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    chk({pc_oe, pd_oe}, 16'h0);
    rd(8'h87, 8'hff);
    rd(8'h88, 8'hff);
    rd(8'h89, 8'h0f);
    chk(an_sel, 3'h7);
    rd(8'h09, 8'h00);
    $display("test reset done");
    repeat (4) begin
      v = 8'($random(seed));
      w = 8'($random(seed));
      pc_in <= 8'($random(seed));
      bus(1'b1, 8'hc1, 8'h00);
      bus(1'b1, 8'h07, v);
      bus(1'b1, 8'h87, w);
      bus(1'b1, 8'h08, w);
      bus(1'b1, 8'h88, v);
      chk({pc_oe, pd_oe}, {~w, ~v});
      chk({pc_out & ~w, pd_out & ~v}, {v & ~w, w & ~v});
      rd(8'h07, pc_in);
      en = 8'($random(seed));
      p_out <= 8'($random(seed));
      p_oe <= 8'($random(seed));
      bus(1'b1, 8'hc1, en);
      xoe = (en & p_oe) | (~en & ~w);
      chk(pc_oe, xoe);
      chk(pc_out & xoe, ((en & p_out) | (~en & v)) & xoe);
    end
    bus(1'b1, 8'hc1, 8'h00);
    $display("test gpio done");
    bus(1'b1, 8'h89, 8'h00);
    chk(pe_oe, 3'h7);
    bus(1'b1, 8'h09, 8'h05);
    chk(pe_out, 3'h5);
    rd(8'h89, 8'h08);
    bus(1'b1, 8'h89, 8'h0f);
    for (int f = 0; f < 4; f++) begin
      fuse <= f[0];
      e3 <= 1'b1;
      v = 8'($random(seed));
      gpx_mpu_model_inst.e_n <= v[6:4];
      bus(1'b1, 8'h9f, {5'h0, v[2:0]});
      chk(an_sel, v[2:0]);
      rd(8'h09, {4'h0, ~f[0], v[6:4] & ~v[2:0]});
    end
    bus(1'b1, 8'h9f, 8'h00);
    gpx_mpu_model_inst.e_n <= 3'h7;
    $display("test port e done");
    bus(1'b1, 8'h89, 8'h17);
    repeat (3) begin
      v = 8'($random(seed));
      w = 8'($random(seed));
      bus(1'b1, 8'h08, v);
      gpx_mpu_model_inst.ext_read(1'b1, got);
      chk(got, v);
      gpx_mpu_model_inst.e_n <= 3'b110;
      repeat (2) @(posedge hclk);
      chk(pd_oe, 8'h00);
      gpx_mpu_model_inst.e_n <= 3'h7;
      q.push_back(w);
      gpx_mpu_model_inst.ext_store(1'b1, w);
      rd(8'h08, q.pop_front());
      gpx_mpu_model_inst.ext_store(1'b0, ~w);
      rd(8'h08, w);
    end
    $display("test slave port done");
    end_of_test();
  end
endmodule
